// ===== rtl/ppl_pkg.sv
/*
 * Shared constants and carrier types for the eight-bit port block:
 * register indices, reset values and the packed structs for the
 * register access port and the static configuration inputs.
 * Assumes a serial engine outside that decodes frames into single
 * register reads and writes and reports when a read byte has left.
 */
package ppl_pkg;

    // Port width and register index width.
    localparam int PORT_W = 8;
    localparam int ADDR_W = 4;

    // Register indices on the access port.
    localparam logic [3:0] IDX_PULLUP_ENABLE     = 4'h0;
    localparam logic [3:0] IDX_INTERRUPT_FLAGS   = 4'h1;
    localparam logic [3:0] IDX_INTERRUPT_CAPTURE = 4'h2;
    localparam logic [3:0] IDX_PORT_VALUE        = 4'h3;
    localparam logic [3:0] IDX_OUTPUT_LATCH      = 4'h4;

    // Reset values.
    localparam logic [7:0] RST_PULLUP_ENABLE     = 8'h00;
    localparam logic [7:0] RST_INTERRUPT_FLAGS   = 8'h00;
    localparam logic [7:0] RST_INTERRUPT_CAPTURE = 8'h00;
    localparam logic [7:0] RST_OUTPUT_LATCH      = 8'h00;
    localparam logic [7:0] RST_READ_DATA         = 8'h00;
    localparam logic [7:0] UNMAPPED_READ         = 8'h00;

    // One register access from the serial engine.
    typedef struct packed {
        logic             rd_en;
        logic             wr_en;
        logic [ADDR_W-1:0] addr;
        logic [PORT_W-1:0] wdata;
    } ppl_req_s;

    // Static configuration held elsewhere in the device.
    typedef struct packed {
        logic [PORT_W-1:0] pin_direction;
        logic [PORT_W-1:0] change_irq_enable;
        logic [PORT_W-1:0] compare_source_select;
        logic [PORT_W-1:0] default_compare_value;
        logic              irq_open_drain;
        logic              irq_polarity;
        logic              clear_on_capture_read;
    } ppl_cfg_s;

endpackage

// ===== rtl/ppl_port.sv
/*
 * Eight-bit port with pull-up enables, output latch, port read path
 * and interrupt-on-change logic (flags, capture, clear on read).
 * Assumes a serial engine on core_clk presenting one-cycle read and
 * write requests, and a read_done pulse once the least significant
 * bit of the last read byte has been shifted out. Pins are async.
 */
// Behaviour
// - Pull-up enable bit connects pin pull-up.
// - Pull-ups apply for inputs and outputs.
// - Flags set only for enabled causing pins.
// - Flag register ignores host writes.
// - Capture stores pin levels on interrupt.
// - Capture held until clearing register read.
// - Port read returns synchronised pin levels.
// - Port write goes into output latch.
// - Latch read returns stored latch value.
// - Latch drives only output pins.
// - Pin-change mode compares against previous value.
// - Default mode compares against default value.
// - Only enabled input pins cause interrupts.
// - First event captures; later ones wait.
// - Active until selected register read; writes ignored.
// - Clear after read byte fully shifted.
// - Pending change re-raises after the clearing register read.
// - Pin-change reference adopts new level.
// - Default mismatch persists after reads.
// - Interrupt output high, low or open-drain.
// - Clearing bit selects capture or port.
// - Compare-source bit selects reference.
// - Open-drain ignores polarity setting.
// - Polarity bit sets driven active level.
`timescale 1ns/1ps

module ppl_port #(
    parameter int PORT_W = ppl_pkg::PORT_W
) (
    // Clock and reset.
    input  wire logic              core_clk,
    input  wire logic              rst,
    // Register access from the serial engine.
    input  wire ppl_pkg::ppl_req_s req,
    input  wire logic              read_done,
    output logic [PORT_W-1:0]      rd_data,
    // Configuration bits from other registers.
    input  wire ppl_pkg::ppl_cfg_s cfg,
    // Port pins.
    input  wire logic [PORT_W-1:0] pin_in,
    output logic [PORT_W-1:0]      pin_out,
    output logic [PORT_W-1:0]      pin_oe,
    output logic [PORT_W-1:0]      pullup_en,
    // Interrupt pin.
    output logic                   irq_out,
    output logic                   irq_oe
);

    logic [PORT_W-1:0] sync1_reg;
    logic [PORT_W-1:0] pin_sync_reg;
    logic [PORT_W-1:0] pullup_reg;
    logic [PORT_W-1:0] latch_reg;
    logic [PORT_W-1:0] flags_reg;
    logic [PORT_W-1:0] capture_reg;
    logic [PORT_W-1:0] ref_reg;
    logic [PORT_W-1:0] rd_data_reg;
    logic [PORT_W-1:0] rd_data_next;
    logic [PORT_W-1:0] ref_next;
    logic [ppl_pkg::ADDR_W-1:0] last_rd_reg;
    logic              active_reg;
    logic              irq_last_reg;

    // Named decode wires.
    wire wr_pullup  = req.wr_en && (req.addr == ppl_pkg::IDX_PULLUP_ENABLE);
    wire wr_port    = req.wr_en && (req.addr == ppl_pkg::IDX_PORT_VALUE);
    wire wr_latch   = req.wr_en && (req.addr == ppl_pkg::IDX_OUTPUT_LATCH);
    wire [PORT_W-1:0] armed;
    wire [PORT_W-1:0] mismatch;
    wire [PORT_W-1:0] diff_default;
    wire [PORT_W-1:0] diff_previous;
    wire              clr_idx_match;
    wire              clr_evt;
    wire              raise;

    // two flop synchroniser
    // The first stage feeds only the second, never any logic.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sync1_reg    <= '0;
            pin_sync_reg <= '0;
        end else begin
            sync1_reg    <= pin_in;
            pin_sync_reg <= sync1_reg;
        end
    end

    // enabled inputs only
    // A pin is armed only when it is an input with change enable set.
    assign armed = cfg.pin_direction & cfg.change_irq_enable;

    // compare source select
    // Each pin picks its own reference, so modes may be mixed per pin.
    // default value compare
    assign diff_default  = pin_sync_reg ^ cfg.default_compare_value;
    assign diff_previous = pin_sync_reg ^ ref_reg;
    assign mismatch = armed & ((cfg.compare_source_select & diff_default)
                      | (~cfg.compare_source_select & diff_previous));

    // raise only when idle
    // While active, new conditions wait; they raise once it clears.
    assign raise = !active_reg && (mismatch != '0);

    // clearing register select
    // The clear keys on the register whose byte just left the device.
    assign clr_idx_match = cfg.clear_on_capture_read
                         ? (last_rd_reg == ppl_pkg::IDX_INTERRUPT_CAPTURE)
                         : (last_rd_reg == ppl_pkg::IDX_PORT_VALUE);
    assign clr_evt = active_reg && read_done && clr_idx_match;

    // reference adopts level
    // Unarmed pins track the pin so that arming starts from the
    // present level instead of a stale one; armed pins move on raise.
    assign ref_next = raise ? pin_sync_reg
                    : ((ref_reg & armed) | (pin_sync_reg & ~armed));

    // interrupt state
    // Writes never touch this flop; only a matching read clears it.
    // clear then re-raise
    // A pending mismatch raises again on the cycle after a clear.
    // default mismatch persists
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            active_reg <= 1'b0;
        end else if (raise) begin
            active_reg <= 1'b1;
        end else if (clr_evt) begin
            active_reg <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            flags_reg   <= ppl_pkg::RST_INTERRUPT_FLAGS;
            capture_reg <= ppl_pkg::RST_INTERRUPT_CAPTURE;
        end else if (raise) begin
            flags_reg   <= mismatch;
            capture_reg <= pin_sync_reg;
        end else if (clr_evt) begin
            flags_reg   <= ppl_pkg::RST_INTERRUPT_FLAGS;
        end
    end

    // Pin-change reference.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ref_reg <= '0;
        end else begin
            ref_reg <= ref_next;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pullup_reg <= ppl_pkg::RST_PULLUP_ENABLE;
            latch_reg  <= ppl_pkg::RST_OUTPUT_LATCH;
        end else begin
            if (wr_pullup) begin
                pullup_reg <= req.wdata;
            end
            if (wr_port || wr_latch) begin
                latch_reg <= req.wdata;
            end
        end
    end

    // register read path
    // Unmapped indices read as zero.
    always_comb begin
        case (req.addr)
            ppl_pkg::IDX_PULLUP_ENABLE:     rd_data_next = pullup_reg;
            ppl_pkg::IDX_INTERRUPT_FLAGS:   rd_data_next = flags_reg;
            ppl_pkg::IDX_INTERRUPT_CAPTURE: rd_data_next = capture_reg;
            ppl_pkg::IDX_PORT_VALUE:        rd_data_next = pin_sync_reg;
            ppl_pkg::IDX_OUTPUT_LATCH:      rd_data_next = latch_reg;
            default: rd_data_next = ppl_pkg::UNMAPPED_READ;
        endcase
    end

    // Read data and the index of the read still being shifted out.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rd_data_reg <= ppl_pkg::RST_READ_DATA;
            last_rd_reg <= '1;
        end else if (req.rd_en) begin
            rd_data_reg <= rd_data_next;
            last_rd_reg <= req.addr;
        end
    end

    // Registered copy of the interrupt active state (active_reg).
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            irq_last_reg <= 1'b0;
        end else begin
            irq_last_reg <= active_reg;
        end
    end

    assign rd_data = rd_data_reg;

    assign pullup_en = pullup_reg;
    // only outputs driven
    // Direction bit 1 means input, so the enable is its inverse.
    assign pin_out = latch_reg;
    assign pin_oe  = ~cfg.pin_direction;

    // driven polarity
    // Open drain pulls low only while active; a driven pin always drives.
    assign irq_out = cfg.irq_open_drain ? 1'b0
                   : (cfg.irq_polarity ? active_reg : ~active_reg);
    assign irq_oe  = cfg.irq_open_drain ? active_reg : 1'b1;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    AST_PULLUP_WRITE:
        assert property (wr_pullup |=> pullup_en == $past(req.wdata))
        else $error("pull-up enables did not follow the write");

    AST_FLAGS_READ_ONLY:
        assert property (req.wr_en
            && req.addr == ppl_pkg::IDX_INTERRUPT_FLAGS
            && active_reg && !clr_evt |=> $stable(flags_reg))
        else $error("flag register changed on a write");

    AST_CAPTURE_HOLD:
        assert property (active_reg && !clr_evt
            |=> $stable(capture_reg) [*2] or !active_reg)
        else $error("capture changed while interrupt active");

    AST_PORT_READ:
        assert property (req.rd_en && req.addr == ppl_pkg::IDX_PORT_VALUE
            |=> rd_data == $past(pin_sync_reg))
        else $error("port read did not return pin levels");

    AST_LATCH_READ:
        assert property (req.rd_en && req.addr == ppl_pkg::IDX_OUTPUT_LATCH
            && !wr_port && !wr_latch |=> rd_data == pin_out)
        else $error("latch read did not return latch value");

    AST_PORT_WRITE_LATCH:
        assert property (wr_port |=> pin_out == $past(req.wdata))
        else $error("port write did not reach the latch");

    AST_OUTPUT_ONLY:
        assert property (((pin_oe & cfg.pin_direction) == 8'h00)
            && (pin_out == $past(pin_out) || $past(wr_port || wr_latch)))
        else $error("input pin driven or latch moved without a write");

    AST_RAISE_CAPTURE:
        assert property (raise |=> active_reg
            && capture_reg == $past(pin_sync_reg)
            && flags_reg == $past(mismatch))
        else $error("raise did not load flags and capture");

    AST_FLAGS_ARMED:
        assert property (raise |=> (flags_reg & ~$past(armed)) == 8'h00)
        else $error("flag set for unarmed pin");

    AST_CLEAR_ON_READ:
        assert property (clr_evt && !raise |=> !active_reg
            && flags_reg == 8'h00)
        else $error("interrupt not cleared after read");

    AST_HOLD_WITHOUT_READ:
        assert property (active_reg && !clr_evt |=> active_reg)
        else $error("interrupt cleared without selected read");

    AST_DEFAULT_PERSISTS:
        assert property (clr_evt && (mismatch & cfg.compare_source_select
            & armed) != 8'h00 ##1 $stable(pin_sync_reg) && $stable(cfg)
            |=> active_reg)
        else $error("default mismatch did not re-raise");

    AST_IRQ_PIN:
        assert property (!cfg.irq_open_drain
            |-> irq_oe && irq_out == (irq_last_reg ~^ cfg.irq_polarity)
                || $changed(active_reg))
        else $error("driven interrupt level wrong");

    AST_OPEN_DRAIN:
        assert property (cfg.irq_open_drain
            |-> !irq_out && irq_oe == active_reg)
        else $error("open-drain interrupt wrong");

    COV_RAISE: cover property (raise);
    COV_CLEAR: cover property (clr_evt);
    COV_RERAISE: cover property (clr_evt ##1 raise);
    COV_DEFAULT: cover property (raise && (cfg.compare_source_select
        & mismatch) != 8'h00);

endmodule

// ===== testbench/ppl_host_model.sv
/*
 * Host side model: issues single register reads and writes to the
 * port block and pulses read_done once a read byte has left.
 * Assumes ppl_pkg is compiled first and a shared core_clk.
 */
`timescale 1ns/1ps

module ppl_host_model (
    // Clock and returned data.
    input  wire logic         core_clk,
    input  wire logic [7:0]   rd_data,
    // Requests toward the port block.
    output ppl_pkg::ppl_req_s req,
    output logic              read_done
);
    // Cycles a byte needs to shift out; a slow host raises this.
    int shift_len = 2;

    // Idle request lines from time zero.
    initial begin
        req = '0;
        read_done = 1'h0;
    end

    // One write, held across exactly one rising edge.
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge core_clk);
        req = '{1'h0, 1'h1, a, d};
        @(negedge core_clk);
        req = '0;
    endtask

    // One read; the byte is taken, shifted out, then read_done pulses.
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(negedge core_clk);
        req = '{1'h1, 1'h0, a, 8'h00};
        @(negedge core_clk);
        req = '0;
        d = rd_data;
        repeat (shift_len) @(negedge core_clk);
        read_done = 1'h1;
        @(negedge core_clk);
        read_done = 1'h0;
    endtask
endmodule

// ===== testbench/ppl_port_tb.sv
/*
 * Self-checking bench for the port block: register access through the
 * host model, random pins and latch values, both interrupt modes and
 * every interrupt pin style. Assumes ppl_pkg, ppl_port and the host
 * model are compiled first.
 */
`timescale 1ns/1ps

module ppl_port_tb;
    logic              core_clk = 1'h0;
    logic              rst = 1'h1;
    logic              read_done;
    logic [7:0]        rd_data;
    logic [7:0]        pin_in = 8'h00;
    logic [7:0]        pin_out;
    logic [7:0]        pin_oe;
    logic [7:0]        pullup_en;
    logic              irq_out;
    logic              irq_oe;
    logic [7:0]        v;
    logic [7:0]        r;
    ppl_pkg::ppl_req_s req;
    ppl_pkg::ppl_cfg_s cfg = '{8'hFF, 8'h00, 8'h00, 8'h00, 1'h0, 1'h1, 1'h0};
    int                miscompares = 0;
    int                checked = 0;
    int                seed = 73;

    // Free running 125 MHz clock.
    always #4 core_clk = ~core_clk;

    ppl_port u_dut (
        .core_clk (core_clk), .rst (rst), .req (req),
        .read_done (read_done), .rd_data (rd_data), .cfg (cfg),
        .pin_in (pin_in), .pin_out (pin_out), .pin_oe (pin_oe),
        .pullup_en (pullup_en), .irq_out (irq_out), .irq_oe (irq_oe));

    ppl_host_model u_host (
        .core_clk (core_clk), .rd_data (rd_data), .req (req),
        .read_done (read_done));

    // Compare and count; a mismatch is reported at once.
    task automatic chk(input string n, input logic [7:0] e,
                       input logic [7:0] g);
        checked++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", n, e, g);
            miscompares++;
        end
    endtask

    // Read one register and compare with the expected byte.
    task automatic rdc(input logic [3:0] a, input logic [7:0] e,
                       input string n);
        u_host.rd(a, r);
        chk(n, e, r);
    endtask

    // Interrupt pin expectation worked out from the pin style.
    task automatic irq(input logic a);
        logic [7:0] e;
        e = cfg.irq_open_drain ? {7'h00, a}
                               : {6'h00, a ~^ cfg.irq_polarity, 1'h1};
        chk("irq pin", e, {6'h00, irq_out & irq_oe, irq_oe});
    endtask

    // New pin levels, then time for the synchroniser and the raise.
    task automatic set_pins(input logic [7:0] p);
        @(negedge core_clk);
        pin_in = p;
        repeat (5) @(negedge core_clk);
    endtask

    // Single exit of the run.
    task automatic final_report;
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Watchdog: the tests need a few thousand cycles at most.
    initial begin
        #400000;
        miscompares++;
        final_report();
    end

    // Main sequence; all inputs change on the falling edge.
    initial begin
        repeat (16) @(negedge core_clk);
        rst = 1'h0;
        for (int i = 0; i < 6; i++) begin
            rdc(4'(i), 8'h00, "reset value");
        end
        chk("pin_out reset", 8'h00, pin_out);
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            v = 8'($random(seed));
            cfg.pin_direction = 8'($random(seed));
            u_host.wr(ppl_pkg::IDX_PULLUP_ENABLE, v);
            rdc(ppl_pkg::IDX_PULLUP_ENABLE, v, "pullup reg");
            chk("pullup_en", v, pullup_en);
            u_host.wr(ppl_pkg::IDX_PORT_VALUE, ~v);
            rdc(ppl_pkg::IDX_OUTPUT_LATCH, ~v, "latch");
            chk("pin_out", ~v, pin_out);
            chk("pin_oe", ~cfg.pin_direction, pin_oe);
            u_host.wr(ppl_pkg::IDX_INTERRUPT_FLAGS, v);
            u_host.wr(ppl_pkg::IDX_INTERRUPT_CAPTURE, v);
            rdc(ppl_pkg::IDX_INTERRUPT_FLAGS, 8'h00, "flags");
            set_pins(8'($random(seed)));
            rdc(ppl_pkg::IDX_PORT_VALUE, pin_in, "port");
        end
        $display("test registers done");
        cfg.pin_direction = 8'hFF;
        set_pins(8'h00);
        cfg.change_irq_enable = 8'h0F;
        set_pins(8'h10);
        irq(1'h0);
        cfg.pin_direction = 8'hFE;
        set_pins(8'h11);
        irq(1'h0);
        cfg.pin_direction = 8'hFF;
        set_pins(8'h13);
        irq(1'h1);
        rdc(ppl_pkg::IDX_INTERRUPT_FLAGS, 8'h02, "flags");
        rdc(ppl_pkg::IDX_INTERRUPT_CAPTURE, 8'h13, "capture");
        set_pins(8'h17);
        rdc(ppl_pkg::IDX_INTERRUPT_CAPTURE, 8'h13, "capture");
        u_host.wr(ppl_pkg::IDX_INTERRUPT_CAPTURE, 8'hFF);
        u_host.wr(ppl_pkg::IDX_PORT_VALUE, 8'hFF);
        irq(1'h1);
        rdc(ppl_pkg::IDX_PORT_VALUE, 8'h17, "port");
        repeat (2) @(negedge core_clk);
        irq(1'h1);
        rdc(ppl_pkg::IDX_INTERRUPT_CAPTURE, 8'h17, "recapture");
        rdc(ppl_pkg::IDX_INTERRUPT_FLAGS, 8'h04, "flags");
        fork
            rdc(ppl_pkg::IDX_PORT_VALUE, 8'h17, "port");
            begin
                repeat (3) @(negedge core_clk);
                irq(1'h1);
            end
        join
        irq(1'h0);
        repeat (4) @(negedge core_clk);
        irq(1'h0);
        $display("test pin change done");
        cfg.clear_on_capture_read = 1'h1;
        cfg.compare_source_select = 8'h0F;
        cfg.default_compare_value = 8'h07;
        set_pins(8'h13);
        irq(1'h1);
        rdc(ppl_pkg::IDX_PORT_VALUE, 8'h13, "port");
        irq(1'h1);
        rdc(ppl_pkg::IDX_INTERRUPT_CAPTURE, 8'h13, "capture");
        repeat (3) @(negedge core_clk);
        irq(1'h1);
        set_pins(8'h17);
        rdc(ppl_pkg::IDX_INTERRUPT_CAPTURE, 8'h13, "capture");
        repeat (3) @(negedge core_clk);
        irq(1'h0);
        $display("test default compare done");
        for (int i = 0; i < 4; i++) begin
            cfg.irq_open_drain = i[1];
            cfg.irq_polarity = i[0];
            @(negedge core_clk);
            irq(1'h0);
            set_pins(8'h13);
            irq(1'h1);
            set_pins(8'h17);
            u_host.rd(ppl_pkg::IDX_INTERRUPT_CAPTURE, r);
            repeat (2) @(negedge core_clk);
        end
        $display("test pin styles done");
        final_report();
    end
endmodule
